// file: common/arith_jump_pkg.sv
package arith_jump_pkg;
  localparam int WORD_W  = 48;
  localparam int ADDR_W  = 15;
  localparam int OP_W    = 6;
  localparam int DES_W   = 3;
  localparam int IDX_MAX = 6;
  localparam int SIGN_B  = 47;
  localparam int EXP_LSB = 36;
  localparam int EXP_W   = 11;
  localparam int COEF_W  = 36;
  localparam int EXP_TOP = 2047;
  localparam int FRAC_W  = 47;

  // Opcodes, octal 13 through 31
  localparam logic [5:0] OP_LOAD_ACC_COMPLEMENT = 6'h0b;
  localparam logic [5:0] OP_ADD                 = 6'h0c;
  localparam logic [5:0] OP_SUB                 = 6'h0d;
  localparam logic [5:0] OP_LOAD_AUX_REG        = 6'h0e;
  localparam logic [5:0] OP_LOAD_AUX_COMPLEMENT = 6'h0f;
  localparam logic [5:0] OP_STORE_ACC           = 6'h10;
  localparam logic [5:0] OP_STORE_AUX_REG       = 6'h11;
  localparam logic [5:0] OP_ACC_COND_JUMP       = 6'h12;
  localparam logic [5:0] OP_AUX_COND_JUMP       = 6'h13;
  localparam logic [5:0] OP_INTEGER_MULTIPLY    = 6'h14;
  localparam logic [5:0] OP_INTEGER_DIVIDE      = 6'h15;
  localparam logic [5:0] OP_FRACTION_MULTIPLY   = 6'h16;
  localparam logic [5:0] OP_FRACTION_DIVIDE     = 6'h17;
  localparam logic [5:0] OP_FLOAT_ADD           = 6'h18;
  localparam logic [5:0] OP_FLOAT_SUBTRACT      = 6'h19;

  localparam logic [2:0] DES_NONE     = 3'h0;
  localparam logic [2:0] DES_INDIRECT = 3'h7;
  localparam int         JMP_RET_B    = 2;
  localparam logic [1:0] COND_ZERO    = 2'h0;
  localparam logic [1:0] COND_NONZERO = 2'h1;
  localparam logic [1:0] COND_POS     = 2'h2;
  localparam logic [1:0] COND_NEG     = 2'h3;

  localparam logic [47:0] WORD_ZERO = 48'h0;
  localparam logic [14:0] ADDR_ONE  = 15'h1;

  typedef struct packed {
    logic [5:0]  op;
    logic [2:0]  des;
    logic [14:0] base;
  } instr_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [14:0] addr;
    logic [47:0] wdata;
  } mem_cmd_t;

  typedef struct packed {
    logic overflow;
    logic divide;
    logic range;
  } fault_t;

  typedef struct packed {
    logic [47:0] word;
    logic [47:0] residue;
    logic        fault;
  } float_res_t;
endpackage : arith_jump_pkg

// file: hw/ones_complement_arith_jump_unit.sv
`timescale 1ns/1ps
module ones_complement_arith_jump_unit
  import arith_jump_pkg::*;
#(
  parameter int IDX_COUNT = IDX_MAX
) (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         rstn,
  // Instruction issue
  input  wire logic                         start,
  input  wire instr_t                       instr,
  input  wire logic [IDX_COUNT*ADDR_W-1:0]  index_regs,
  input  wire logic [ADDR_W-1:0]            next_step,
  output logic                              done_q,
  output logic                              jump_q,
  output logic [ADDR_W-1:0]                 jump_addr_q,
  // Core storage
  output mem_cmd_t                          mem_q,
  input  wire logic                         mem_ack,
  input  wire logic [WORD_W-1:0]            mem_rdata,
  // Operational registers
  output logic [WORD_W-1:0]                 acc_q,
  output logic [WORD_W-1:0]                 aux_q,
  // Fault indicators and interrupts
  input  wire fault_t                       irq_select,
  input  wire fault_t                       ind_clear,
  output fault_t                            ind_q,
  output fault_t                            irq_q
);

  if (IDX_COUNT < 1 || IDX_COUNT > IDX_MAX) begin : g_idx_range
    $error("IDX_COUNT must be 1 to 6");
  end

  typedef enum logic [2:0] {ST_IDLE, ST_INDIRECT, ST_READ, ST_EXEC, ST_WRITE} state_t;

  // Subtractive adder: the borrow wraps around, so -0 appears only for (-0) - (+0)
  function automatic logic [47:0] oc_sub(input logic [47:0] a, input logic [47:0] b);
    logic [48:0] d;
    d = {1'b0, a} - {1'b0, b};
    oc_sub = d[48] ? (d[47:0] - 48'h1) : d[47:0];
  endfunction : oc_sub

  function automatic logic [47:0] mag(input logic [47:0] x);
    mag = x[SIGN_B] ? ~x : x;
  endfunction : mag

  function automatic logic [14:0] addr_add(input logic [14:0] a, input logic [14:0] b);
    logic [15:0] s;
    s = {1'b0, a} + {1'b0, b};
    addr_add = s[14:0] + {14'h0, s[15]};
  endfunction : addr_add

  function automatic logic jump_test(input logic [47:0] r, input logic [1:0] c);
    logic z;
    z = (r == WORD_ZERO) || (r == ~WORD_ZERO);
    case (c)
      COND_ZERO:    jump_test = z;
      COND_NONZERO: jump_test = !z;
      COND_POS:     jump_test = !r[SIGN_B];
      default:      jump_test = r[SIGN_B];
    endcase
  endfunction : jump_test

  function automatic float_res_t fadd(input logic [47:0] a, input logic [47:0] b);
    logic [47:0] ma, mb, t;
    logic        sa, sb, sr;
    logic [72:0] big, sml, sum;
    logic [36:0] coef;
    int          ea, eb, e, dif;
    sa = a[SIGN_B];
    sb = b[SIGN_B];
    ma = mag(a);
    mb = mag(b);
    if (ma[46:EXP_LSB] < mb[46:EXP_LSB]) begin
      {ma, mb} = {mb, ma};
      {sa, sb} = {sb, sa};
    end
    ea = int'(ma[46:EXP_LSB]);
    eb = int'(mb[46:EXP_LSB]);
    dif = ea - eb;
    big = {1'b0, ma[COEF_W-1:0], 36'h0};
    sml = (dif > 71) ? 73'h0 : ({1'b0, mb[COEF_W-1:0], 36'h0} >> dif);
    sr = sa;
    if (sa == sb) begin
      sum = big + sml;
    end else if (big >= sml) begin
      sum = big - sml;
    end else begin
      sum = sml - big;
      sr = sb;
    end
    e = ea;
    if (sum[72]) begin
      sum = sum >> 1;
      e = e + 1;
    end
    for (int i = 0; i < 72; i++) begin
      if (!sum[71] && sum != 73'h0) begin
        sum = sum << 1;
        e = e - 1;
      end
    end
    // Round half up on the first lost bit; the lost bits stay visible as residue
    coef = {1'b0, sum[71:36]} + {36'h0, sum[35]};
    if (coef[36]) begin
      coef = coef >> 1;
      e = e + 1;
    end
    fadd.residue = {12'h0, sum[35:0]};
    fadd.fault = (sum != 73'h0) && (e > EXP_TOP || e < 0);
    if (sum == 73'h0) begin
      fadd.word = WORD_ZERO;
    end else begin
      t = {1'b0, e[EXP_W-1:0], coef[COEF_W-1:0]};
      fadd.word = sr ? ~t : t;
    end
  endfunction : fadd

  state_t      state_q;
  instr_t      ins_q;
  logic [47:0] opnd_q;

  // Address and operand selection
  wire [2:0]   des_w     = instr.des;
  wire [14:0]  idx_w     = (des_w == DES_NONE || des_w == DES_INDIRECT || int'(des_w) > IDX_COUNT) ? 15'h0 :
                           index_regs[(int'(des_w)-1)*ADDR_W +: ADDR_W];
  wire [14:0]  ea_w      = addr_add(instr.base, idx_w);
  wire         op_ok_w   = instr.op >= OP_LOAD_ACC_COMPLEMENT && instr.op <= OP_FLOAT_SUBTRACT;
  wire         is_jump_w = instr.op == OP_ACC_COND_JUMP || instr.op == OP_AUX_COND_JUMP;
  wire         is_st_w   = instr.op == OP_STORE_ACC || instr.op == OP_STORE_AUX_REG;
  wire [47:0]  test_r_w  = (instr.op == OP_ACC_COND_JUMP) ? acc_q : aux_q;
  wire         taken_w   = jump_test(test_r_w, instr.des[1:0]);
  wire         ret_w     = instr.des[JMP_RET_B];

  // Fixed add and subtract
  wire [47:0]  sum_w     = oc_sub(acc_q, ~opnd_q);
  wire [47:0]  dif_w     = oc_sub(acc_q, opnd_q);
  wire         add_ov_w  = (acc_q[SIGN_B] == opnd_q[SIGN_B]) && (sum_w[SIGN_B] != acc_q[SIGN_B]);
  wire         sub_ov_w  = (acc_q[SIGN_B] != opnd_q[SIGN_B]) && (dif_w[SIGN_B] != acc_q[SIGN_B]);

  // Multiply on magnitudes, sign applied to the whole double word
  wire         msgn_w    = acc_q[SIGN_B] ^ opnd_q[SIGN_B];
  wire [93:0]  prod_w    = (acc_q[46:0] ^ {47{acc_q[47]}}) * (opnd_q[46:0] ^ {47{opnd_q[47]}});
  wire [95:0]  imul_w    = msgn_w ? ~{2'b00, prod_w} : {2'b00, prod_w};
  wire [95:0]  fmul_w    = msgn_w ? ~{1'b0, prod_w, 1'b0} : {1'b0, prod_w, 1'b0};

  // Divide; single-cycle array, slow but within a 100 ns period budget is the user's concern
  wire [95:0]  idvd_w    = {aux_q, acc_q};
  wire [95:0]  fdvd_w    = {acc_q, aux_q};
  wire [95:0]  idmag_w   = idvd_w[95] ? ~idvd_w : idvd_w;
  wire [95:0]  fdmag_w   = fdvd_w[95] ? ~fdvd_w : fdvd_w;
  wire [47:0]  dvs_w     = mag(opnd_q);
  wire [95:0]  iquo_w    = (dvs_w == WORD_ZERO) ? 96'h0 : idmag_w / {48'h0, dvs_w};
  wire [95:0]  irem_w    = (dvs_w == WORD_ZERO) ? 96'h0 : idmag_w % {48'h0, dvs_w};
  wire [95:0]  fquo_w    = (dvs_w == WORD_ZERO) ? 96'h0 : fdmag_w / {47'h0, dvs_w, 1'b0};
  wire [95:0]  frem_w    = (dvs_w == WORD_ZERO) ? 96'h0 : fdmag_w % {47'h0, dvs_w, 1'b0};
  wire         iov_w     = (dvs_w == WORD_ZERO) || (iquo_w[95:FRAC_W] != 49'h0);
  wire         fov_w     = (dvs_w == WORD_ZERO) || (fquo_w[95:FRAC_W] != 49'h0);
  wire         qsgn_i_w  = idvd_w[95] ^ opnd_q[SIGN_B];
  wire         qsgn_f_w  = fdvd_w[95] ^ opnd_q[SIGN_B];
  wire [47:0]  iq_w      = qsgn_i_w ? ~iquo_w[47:0] : iquo_w[47:0];
  wire [47:0]  ir_w      = idvd_w[95] ? ~irem_w[47:0] : irem_w[47:0];
  wire [47:0]  fq_w      = qsgn_f_w ? ~fquo_w[47:0] : fquo_w[47:0];
  wire [47:0]  fr_w      = fdvd_w[95] ? ~frem_w[47:0] : frem_w[47:0];

  // Floating add and subtract share one path; subtract feeds the negated operand
  wire         fsub_w    = ins_q.op == OP_FLOAT_SUBTRACT;
  float_res_t  flt_w;
  assign flt_w = fadd(acc_q, fsub_w ? ~opnd_q : opnd_q);

  // Faults raised by the executing instruction
  fault_t      ev_w;
  assign ev_w.overflow = state_q == ST_EXEC &&
                         ((ins_q.op == OP_ADD && add_ov_w) || (ins_q.op == OP_SUB && sub_ov_w));
  assign ev_w.divide   = state_q == ST_EXEC &&
                         ((ins_q.op == OP_INTEGER_DIVIDE && iov_w) ||
                          (ins_q.op == OP_FRACTION_DIVIDE && fov_w));
  assign ev_w.range    = state_q == ST_EXEC && flt_w.fault &&
                         (ins_q.op == OP_FLOAT_ADD || fsub_w);

  // Set wins over clear so a fault in the clearing cycle is kept
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ind_q <= '0;
      irq_q <= '0;
    end else begin
      ind_q <= (ind_q & ~ind_clear) | ev_w;
      irq_q <= ev_w & irq_select;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q     <= ST_IDLE;
      ins_q       <= '0;
      opnd_q      <= '0;
      mem_q       <= '0;
      acc_q       <= '0;
      aux_q       <= '0;
      done_q      <= 1'b0;
      jump_q      <= 1'b0;
      jump_addr_q <= '0;
    end else begin
      done_q <= 1'b0;
      jump_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (start && !op_ok_w) begin
            done_q <= 1'b1;
          end else if (start && is_jump_w) begin
            // Jump address is never indexed
            if (!taken_w) begin
              done_q <= 1'b1;
            end else if (!ret_w) begin
              jump_q      <= 1'b1;
              jump_addr_q <= instr.base;
              done_q      <= 1'b1;
            end else begin
              ins_q       <= instr;
              jump_addr_q <= addr_add(instr.base, ADDR_ONE);
              mem_q       <= '{req: 1'b1, we: 1'b1, addr: instr.base, wdata: {33'h0, next_step}};
              state_q     <= ST_WRITE;
            end
          end else if (start) begin
            ins_q <= instr;
            if (instr.des == DES_INDIRECT) begin
              mem_q   <= '{req: 1'b1, we: 1'b0, addr: instr.base, wdata: WORD_ZERO};
              state_q <= ST_INDIRECT;
            end else if (is_st_w) begin
              mem_q   <= '{req: 1'b1, we: 1'b1, addr: ea_w,
                           wdata: (instr.op == OP_STORE_ACC) ? acc_q : aux_q};
              state_q <= ST_WRITE;
            end else begin
              mem_q   <= '{req: 1'b1, we: 1'b0, addr: ea_w, wdata: WORD_ZERO};
              state_q <= ST_READ;
            end
          end
        end
        ST_INDIRECT: begin
          if (mem_ack) begin
            if (ins_q.op == OP_STORE_ACC || ins_q.op == OP_STORE_AUX_REG) begin
              mem_q   <= '{req: 1'b1, we: 1'b1, addr: mem_rdata[ADDR_W-1:0],
                           wdata: (ins_q.op == OP_STORE_ACC) ? acc_q : aux_q};
              state_q <= ST_WRITE;
            end else begin
              mem_q   <= '{req: 1'b1, we: 1'b0, addr: mem_rdata[ADDR_W-1:0], wdata: WORD_ZERO};
              state_q <= ST_READ;
            end
          end
        end
        ST_READ: begin
          if (mem_ack) begin
            mem_q   <= '0;
            opnd_q  <= mem_rdata;
            state_q <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          case (ins_q.op)
            OP_LOAD_ACC_COMPLEMENT: acc_q <= ~opnd_q;
            OP_ADD:                 acc_q <= sum_w;
            OP_SUB:                 acc_q <= dif_w;
            OP_LOAD_AUX_REG:        aux_q <= opnd_q;
            OP_LOAD_AUX_COMPLEMENT: aux_q <= ~opnd_q;
            OP_INTEGER_MULTIPLY: begin
              aux_q <= imul_w[95:48];
              acc_q <= imul_w[47:0];
            end
            OP_FRACTION_MULTIPLY: begin
              acc_q <= fmul_w[95:48];
              aux_q <= fmul_w[47:0];
            end
            OP_INTEGER_DIVIDE: begin
              // On overflow both registers are left as they were
              if (!iov_w) begin
                acc_q <= iq_w;
                aux_q <= ir_w;
              end
            end
            OP_FRACTION_DIVIDE: begin
              if (!fov_w) begin
                acc_q <= fq_w;
                aux_q <= fr_w;
              end
            end
            OP_FLOAT_ADD, OP_FLOAT_SUBTRACT: begin
              acc_q <= flt_w.word;
              aux_q <= flt_w.residue;
            end
            default: begin
            end
          endcase
          done_q  <= 1'b1;
          state_q <= ST_IDLE;
        end
        ST_WRITE: begin
          if (mem_ack) begin
            mem_q   <= '0;
            done_q  <= 1'b1;
            jump_q  <= ins_q.op == OP_ACC_COND_JUMP || ins_q.op == OP_AUX_COND_JUMP;
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

endmodule : ones_complement_arith_jump_unit

// file: tb/core_storage_model.sv
`timescale 1ns/1ps
module core_storage_model
  import arith_jump_pkg::*;
(
  // Clock
  input  wire logic       clk,
  // Request and answer
  input  wire mem_cmd_t   cmd,
  input  wire logic [1:0] lag,
  output logic            ack,
  output logic [47:0]     rdata
);
  logic [47:0] mem [2**ADDR_W];
  logic [1:0]  wait_q = 2'h0;
  initial ack = 1'b0;
  initial rdata = 48'h0;
  // Data toggles outside the ack cycle so stale words never pass
  always @(posedge clk) begin
    rdata <= ~rdata;
    if (ack) begin
      ack <= 1'b0;
    end else if (cmd.req && wait_q == lag) begin
      ack <= 1'b1;
      wait_q <= 2'h0;
      if (cmd.we) mem[cmd.addr] <= cmd.wdata;
      else rdata <= mem[cmd.addr];
    end else if (cmd.req) begin
      wait_q <= wait_q + 2'h1;
    end
  end
endmodule : core_storage_model

// file: tb/ones_complement_arith_jump_unit_checker.sv
`timescale 1ns/1ps
module ones_complement_arith_jump_unit_checker
  import arith_jump_pkg::*;
#(
  parameter int IDX_COUNT = IDX_MAX
) (
  // Clock and reset
  input wire logic                        clk,
  input wire logic                        rstn,
  // Issue
  input wire logic                        start,
  input wire instr_t                      instr,
  input wire logic [IDX_COUNT*ADDR_W-1:0] index_regs,
  input wire logic [ADDR_W-1:0]           next_step,
  input wire logic                        done_q,
  input wire logic                        jump_q,
  input wire logic [ADDR_W-1:0]           jump_addr_q,
  // Storage
  input wire mem_cmd_t                    mem_q,
  input wire logic                        mem_ack,
  input wire logic [WORD_W-1:0]           mem_rdata,
  // Registers and faults
  input wire logic [WORD_W-1:0]           acc_q,
  input wire logic [WORD_W-1:0]           aux_q,
  input wire fault_t                      irq_select,
  input wire fault_t                      ind_clear,
  input wire fault_t                      ind_q,
  input wire fault_t                      irq_q
);
  logic        busy_q;
  instr_t      ins_q;
  logic [47:0] acc_s_q;
  logic [47:0] rd_q;
  wire         take = start && (!busy_q || done_q);
  // Snapshot at issue, since acc_q moves on the same edge that raises done
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy_q  <= 1'b0;
      ins_q   <= '0;
      acc_s_q <= '0;
      rd_q    <= '0;
    end else begin
      busy_q <= take || (busy_q && !done_q);
      if (take) ins_q <= instr;
      if (take) acc_s_q <= acc_q;
      if (mem_ack && !mem_q.we) rd_q <= mem_rdata;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_acc_cload: assert property (
    done_q && ins_q.op == OP_LOAD_ACC_COMPLEMENT |-> acc_q == ~rd_q) else $error("complement load wrong");
  chk_aux_load: assert property (
    done_q && ins_q.op == OP_LOAD_AUX_REG |-> aux_q == rd_q) else $error("aux load wrong");
  chk_aux_cload: assert property (
    done_q && ins_q.op == OP_LOAD_AUX_COMPLEMENT |-> aux_q == ~rd_q) else $error("aux complement wrong");
  chk_acc_store: assert property (
    mem_q.req && mem_q.we && ins_q.op == OP_STORE_ACC |-> mem_q.wdata == acc_q && acc_q == acc_s_q)
    else $error("acc store wrong");
  chk_aux_store: assert property (
    mem_q.req && mem_q.we && ins_q.op == OP_STORE_AUX_REG |-> mem_q.wdata == aux_q) else $error("aux store wrong");
  chk_add_negzero: assert property (
    done_q && ins_q.op == OP_ADD && acc_q == '1 |-> acc_s_q == '1 && rd_q == '1) else $error("stray negative zero");
  chk_ovf_cause: assert property (
    irq_q.overflow |-> done_q && ind_q.overflow && $past(irq_select.overflow)) else $error("overflow irq wrong");
  chk_div_fault: assert property (
    irq_q.divide |-> done_q && ind_q.divide && acc_q == acc_s_q) else $error("divide fault wrong");
  chk_jump_target: assert property (
    jump_q |-> jump_addr_q == ins_q.base + {14'h0, ins_q.des[2]}) else $error("jump target wrong");
  chk_req_hold: assert property (
    mem_q.req && !mem_ack |=> mem_q.req && $stable(mem_q.addr)) else $error("request dropped");
endmodule : ones_complement_arith_jump_unit_checker

bind ones_complement_arith_jump_unit ones_complement_arith_jump_unit_checker #(.IDX_COUNT(IDX_COUNT)) chk_i (
  .clk(clk), .rstn(rstn), .start(start), .instr(instr), .index_regs(index_regs), .next_step(next_step),
  .done_q(done_q), .jump_q(jump_q), .jump_addr_q(jump_addr_q), .mem_q(mem_q), .mem_ack(mem_ack),
  .mem_rdata(mem_rdata), .acc_q(acc_q), .aux_q(aux_q), .irq_select(irq_select), .ind_clear(ind_clear),
  .ind_q(ind_q), .irq_q(irq_q));

// file: tb/ones_complement_arith_jump_unit_test.sv
`timescale 1ns/1ps
module ones_complement_arith_jump_unit_test
  import arith_jump_pkg::*;
;
  logic clk = 1'b0, rstn = 1'b0, start = 1'b0, mem_ack, done_q, jump_q;
  instr_t instr = '0;
  logic [89:0] index_regs = {15'h60, 15'h50, 15'h40, 15'h30, 15'h20, 15'h5};
  logic [14:0] next_step = 15'h0123, jump_addr_q;
  mem_cmd_t mem_q;
  logic [47:0] mem_rdata, acc_q, aux_q;
  fault_t irq_select = '1, ind_clear = '0, ind_q, irq_q;
  logic [1:0] lag = 2'h0;
  int fail_count = 0, checked = 0;
  ones_complement_arith_jump_unit dut (.clk(clk), .rstn(rstn), .start(start), .instr(instr),
    .index_regs(index_regs), .next_step(next_step), .done_q(done_q), .jump_q(jump_q), .jump_addr_q(jump_addr_q),
    .mem_q(mem_q), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .acc_q(acc_q), .aux_q(aux_q),
    .irq_select(irq_select), .ind_clear(ind_clear), .ind_q(ind_q), .irq_q(irq_q));
  core_storage_model core (.clk(clk), .cmd(mem_q), .lag(lag), .ack(mem_ack), .rdata(mem_rdata));
  initial begin
    forever #50 clk = ~clk;
  end
  task automatic summarize;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  // Issues at a falling edge, one cycle after the previous done, so starts never land on done
  task automatic run(input logic [5:0] op, input logic [2:0] d, input logic [14:0] b);
    int n = 0;
    // One idle cycle so start is never lowered and raised in one step
    @(negedge clk);
    instr = '{op, d, b};
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    while (done_q !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    if (n == 40) chk(48'h0, 48'h1);
  endtask : run
  task automatic op_m(input logic [5:0] op, input logic [47:0] v);
    core.mem[15'h0300] = v;
    run(op, 3'h0, 15'h0300);
  endtask : op_m
  task automatic seta(input logic [47:0] v);
    op_m(OP_LOAD_ACC_COMPLEMENT, ~v);
  endtask : seta
  task automatic setq(input logic [47:0] v);
    op_m(OP_LOAD_AUX_REG, v);
  endtask : setq
  task automatic clr;
    ind_clear = '1;
    @(negedge clk);
    ind_clear = '0;
  endtask : clr
  task automatic t_loads;
    core.mem[15'h0105] = 48'h0123_4567_89ab;
    core.mem[15'h0200] = 48'h0105;
    run(OP_LOAD_ACC_COMPLEMENT, 3'h1, 15'h0100);
    chk(acc_q, 48'hfedc_ba98_7654);
    run(OP_LOAD_AUX_REG, 3'h7, 15'h0200);
    chk(aux_q, 48'h0123_4567_89ab);
    run(OP_LOAD_AUX_COMPLEMENT, 3'h1, 15'h0100);
    chk(aux_q, 48'hfedc_ba98_7654);
    setq('1);
    chk(aux_q, '1);
  endtask : t_loads
  task automatic t_addsub;
    seta(48'h5);
    op_m(OP_ADD, 48'h3);
    chk(acc_q, 48'h8);
    seta(~48'h1);
    op_m(OP_ADD, 48'h3);
    chk(acc_q, 48'h2);
    seta(48'h7fff_ffff_ffff);
    op_m(OP_ADD, 48'h1);
    chk({ind_q, irq_q}, 48'h24);
    clr();
    seta('1);
    op_m(OP_ADD, '1);
    chk(acc_q, '1);
    seta('1);
    op_m(OP_SUB, '0);
    chk(acc_q, '1);
    seta(48'h8);
    op_m(OP_SUB, 48'h3);
    chk(acc_q, 48'h5);
    seta(48'h8000_0000_0000);
    op_m(OP_SUB, 48'h1);
    chk({ind_q, irq_q}, 48'h24);
    clr();
  endtask : t_addsub
  task automatic t_store;
    lag = 2'h2;
    seta(48'h1111_2222_3333);
    setq(48'h4444_5555_6666);
    run(OP_STORE_ACC, 3'h1, 15'h0400);
    chk(core.mem[15'h0405], 48'h1111_2222_3333);
    chk(acc_q, 48'h1111_2222_3333);
    run(OP_STORE_AUX_REG, 3'h0, 15'h0401);
    chk(core.mem[15'h0401], 48'h4444_5555_6666);
    chk(aux_q, 48'h4444_5555_6666);
    lag = 2'h0;
  endtask : t_store
  task automatic t_jumps;
    logic [47:0] v;
    logic z;
    logic t;
    for (int r = 0; r < 2; r++)
      for (int k = 0; k < 4; k++)
        for (int j = 0; j < 8; j++) begin
          v = k[1] ? (k[0] ? ~48'h5 : 48'h5) : (k[0] ? '1 : '0);
          z = k < 2;
          if (r == 0) seta(v);
          else setq(v);
          core.mem[15'h0500] = '0;
          run(r ? OP_AUX_COND_JUMP : OP_ACC_COND_JUMP, 3'(j), 15'h0500);
          t = j[1] ? (v[47] == j[0]) : (z != j[0]);
          // Sign tests on zero are left open
          if (!(z && j[1])) begin
            chk(48'(jump_q), 48'(t));
            if (t) chk(48'(jump_addr_q), 48'(j[2] ? 15'h0501 : 15'h0500));
            if (t && j[2]) chk(core.mem[15'h0500], 48'h0123);
          end
        end
  endtask : t_jumps
  task automatic t_muldiv;
    seta(~48'h3);
    op_m(OP_INTEGER_MULTIPLY, 48'h5);
    chk(aux_q, '1);
    chk(acc_q, ~48'hf);
    setq('1);
    seta(~48'h11);
    op_m(OP_INTEGER_DIVIDE, 48'h5);
    chk(acc_q, ~48'h3);
    chk(aux_q, ~48'h2);
    op_m(OP_INTEGER_DIVIDE, 48'h0);
    chk({ind_q, irq_q, acc_q[41:0]}, {6'h12, ~42'h3});
    clr();
    seta(48'h4000_0000_0000);
    op_m(OP_FRACTION_MULTIPLY, 48'h4000_0000_0000);
    chk(acc_q, 48'h2000_0000_0000);
    chk(aux_q, 48'h0);
    op_m(OP_FRACTION_DIVIDE, 48'h4000_0000_0000);
    chk(acc_q, 48'h4000_0000_0000);
    chk(aux_q, 48'h0);
  endtask : t_muldiv
  task automatic t_float;
    seta({1'b0, 11'h400, 36'h8_0000_0000});
    op_m(OP_FLOAT_ADD, {1'b0, 11'h400, 36'h8_0000_0000});
    chk(acc_q, {1'b0, 11'h401, 36'h8_0000_0000});
    chk(aux_q, 48'h0);
    seta({1'b0, 11'h400, 36'hc_0000_0000});
    op_m(OP_FLOAT_SUBTRACT, {1'b0, 11'h400, 36'h8_0000_0000});
    chk(acc_q, {1'b0, 11'h3ff, 36'h8_0000_0000});
    seta({1'b0, 11'h7ff, 36'h8_0000_0000});
    op_m(OP_FLOAT_ADD, {1'b0, 11'h7ff, 36'h8_0000_0000});
    chk({ind_q, irq_q}, 48'h9);
    clr();
  endtask : t_float
  initial begin
    #2000000;
    chk(48'h0, 48'h1);
    summarize();
  end
  initial begin
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    t_loads();
    t_addsub();
    t_store();
    t_jumps();
    t_muldiv();
    t_float();
    summarize();
  end
endmodule : ones_complement_arith_jump_unit_test
